// ==== inc/cfs_pkg.sv ====
package cfs_pkg;

   // ------------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] CFS_FAULT_STATUS_1_OFF = 8'h21;
   localparam logic [7:0] CFS_EVENT_FLAGS_0_OFF = 8'h22;
   localparam logic [7:0] CFS_EVENT_FLAGS_1_OFF = 8'h23;
   localparam logic [7:0] CFS_EVENT_FLAGS_2_OFF = 8'h24;
   localparam logic [7:0] CFS_REG_RESET = 8'h00;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int CFS_FS_SYS_SHORT_BIT = 7;
   localparam int CFS_FS_SYS_OVP_BIT = 6;
   localparam int CFS_FS_REV_OVP_BIT = 5;
   localparam int CFS_FS_REV_UVP_BIT = 4;
   localparam int CFS_FS_TSHUT_BIT = 2;
   localparam logic [7:0] CFS_FS_USED_MASK = 8'hF4;
   localparam logic [7:0] CFS_F1_USED_MASK = 8'hD7;
   localparam logic [7:0] CFS_F2_USED_MASK = 8'h7F;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic system_short_status;
      logic system_overvoltage_status;
      logic reverse_output_overvoltage_status;
      logic reverse_output_undervoltage_status;
      logic thermal_shutdown_status;
   } cfs_fault_in_t;

   // Live levels watched for edges or changes
   typedef struct packed {
      logic input_current_limit_regulation;    // Or reverse output current regulation
      logic input_voltage_limit_regulation;    // Or reverse output voltage regulation
      logic watchdog_expired;
      logic weak_source;
      logic power_good_status;
      logic second_input_present;
      logic first_input_present;
      logic bus_voltage_present;
      logic [2:0] charge_state;
      logic [1:0] optimizer_state;
      logic [3:0] bus_voltage_state;
      logic thermal_regulation;
      logic battery_present;
      logic charger_type_detect_busy;
      logic data_line_detect_done;
      logic adc_one_shot_mode;
      logic adc_conversion_done;
      logic min_system_voltage_regulation;
      logic fast_charge_expired;
      logic trickle_expired;
      logic precharge_expired;
      logic topoff_expired;
   } cfs_event_in_t;

   typedef struct packed {
      logic [7:0] fault_status_1_r;
      logic [7:0] charger_event_flags_0_r;
      logic [7:0] charger_event_flags_1_r;
      logic [7:0] charger_event_flags_2_r;
      cfs_event_in_t prev_r;
      logic [7:0] rd_data_r;
      logic rd_valid_r;
      logic [7:0] event_pending_r;
      logic irq_pulse_r;
   } cfs_state_t;

endpackage : cfs_pkg

// ==== hdl/cfs_flag_bank.sv ====
`timescale 1ns/100ps
`default_nettype none

module cfs_flag_bank
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire cfs_pkg::cfs_fault_in_t fault_in,
   input wire cfs_pkg::cfs_event_in_t event_in,
   input wire logic [7:0] event_mask,
   input wire logic rd_en,
   input wire logic wr_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic irq_pulse
);
   import cfs_pkg::*;

   // ------------------------------------------------------------------
   // State and per-cycle terms
   // ------------------------------------------------------------------
   cfs_state_t st_r;
   cfs_state_t st_nxt;
   logic [7:0] set0;
   logic [7:0] set1;
   logic [7:0] set2;

   // Fault and read path
   logic [7:0] fault_now;
   logic sel_fault;
   logic sel_flag0;
   logic sel_flag1;
   logic sel_flag2;
   logic [7:0] rd_word;

   // Next flag values
   logic [7:0] flags0_nxt;
   logic [7:0] flags1_nxt;
   logic [7:0] flags2_nxt;

   // Interrupt staging
   logic [7:0] irq_candidates;

   // Flag 0 detectors
   logic det_current_limit;
   logic det_voltage_limit;
   logic det_watchdog;
   logic det_weak_source;
   logic det_power_good;
   logic det_second_input;
   logic det_first_input;
   logic det_bus_present;

   // Flag 1 detectors
   logic det_charge_state;
   logic det_optimizer;
   logic det_bus_state;
   logic det_thermal_reg;
   logic det_battery;
   logic det_charger_type;

   // Flag 2 detectors
   logic det_data_line;
   logic det_conversion;
   logic det_min_system;
   logic det_fast_charge;
   logic det_trickle;
   logic det_precharge;
   logic det_topoff;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic rise(input logic now, input logic was);
      rise = now & ~was;
   endfunction : rise

   function automatic logic toggled(input logic now, input logic was);
      toggled = now ^ was;
   endfunction : toggled

   // Narrow status fields are zero-extended so one helper serves all widths
   function automatic logic moved(input logic [3:0] now, input logic [3:0] was);
      moved = now != was;
   endfunction : moved

   function automatic logic hit(input logic en, input logic [7:0] at,
                                input logic [7:0] off);
      hit = en && at == off;
   endfunction : hit

   // Set wins over the read clear so an event landing on a read survives
   function automatic logic [7:0] latch(input logic [7:0] cur, input logic [7:0] set,
                                        input logic clr, input logic [7:0] used);
      latch = ((clr ? 8'h00 : cur) | set) & used;
   endfunction : latch

   // ------------------------------------------------------------------
   // Flag 0 detection: regulation, watchdog and source events
   // ------------------------------------------------------------------
   always_comb
   begin
      det_current_limit = rise(event_in.input_current_limit_regulation,
                               st_r.prev_r.input_current_limit_regulation);

      det_voltage_limit = rise(event_in.input_voltage_limit_regulation,
                               st_r.prev_r.input_voltage_limit_regulation);

      det_watchdog = rise(event_in.watchdog_expired,
                          st_r.prev_r.watchdog_expired);

      det_weak_source = rise(event_in.weak_source,
                             st_r.prev_r.weak_source);

      // Both directions count: losing a good adapter matters as much as gaining one
      det_power_good = toggled(event_in.power_good_status,
                               st_r.prev_r.power_good_status);

      det_second_input = toggled(event_in.second_input_present,
                                 st_r.prev_r.second_input_present);

      det_first_input = toggled(event_in.first_input_present,
                                st_r.prev_r.first_input_present);

      det_bus_present = toggled(event_in.bus_voltage_present,
                                st_r.prev_r.bus_voltage_present);
   end

   // ------------------------------------------------------------------
   // Flag 0 assembly
   // ------------------------------------------------------------------
   always_comb
   begin
      set0 = 8'h00;
      set0[7] = det_current_limit;
      set0[6] = det_voltage_limit;
      set0[5] = det_watchdog;
      set0[4] = det_weak_source;
      set0[3] = det_power_good;
      set0[2] = det_second_input;
      set0[1] = det_first_input;
      set0[0] = det_bus_present;
   end

   // ------------------------------------------------------------------
   // Flag 1 detection: charge, optimizer, bus and battery events
   // ------------------------------------------------------------------
   always_comb
   begin
      det_charge_state = moved({1'b0, event_in.charge_state},
                               {1'b0, st_r.prev_r.charge_state});

      det_optimizer = moved({2'b00, event_in.optimizer_state},
                            {2'b00, st_r.prev_r.optimizer_state});

      det_bus_state = moved(event_in.bus_voltage_state,
                            st_r.prev_r.bus_voltage_state);

      det_thermal_reg = rise(event_in.thermal_regulation,
                             st_r.prev_r.thermal_regulation);

      det_battery = toggled(event_in.battery_present,
                            st_r.prev_r.battery_present);

      det_charger_type = toggled(event_in.charger_type_detect_busy,
                                 st_r.prev_r.charger_type_detect_busy);
   end

   // ------------------------------------------------------------------
   // Flag 1 assembly
   // ------------------------------------------------------------------
   // Reserved bits 5 and 3 are never set, and the used mask keeps them clear
   always_comb
   begin
      set1 = 8'h00;
      set1[7] = det_charge_state;
      set1[6] = det_optimizer;
      set1[4] = det_bus_state;
      set1[2] = det_thermal_reg;
      set1[1] = det_battery;
      set1[0] = det_charger_type;
   end

   // ------------------------------------------------------------------
   // Flag 2 detection: detection done, conversion, regulation and timers
   // ------------------------------------------------------------------
   always_comb
   begin
      det_data_line = rise(event_in.data_line_detect_done,
                           st_r.prev_r.data_line_detect_done);

      // Continuous conversions would flood the flag, so only one-shot counts
      det_conversion = event_in.adc_one_shot_mode
                       & rise(event_in.adc_conversion_done,
                              st_r.prev_r.adc_conversion_done);

      det_min_system = toggled(event_in.min_system_voltage_regulation,
                               st_r.prev_r.min_system_voltage_regulation);

      det_fast_charge = rise(event_in.fast_charge_expired,
                             st_r.prev_r.fast_charge_expired);

      det_trickle = rise(event_in.trickle_expired,
                         st_r.prev_r.trickle_expired);

      det_precharge = rise(event_in.precharge_expired,
                           st_r.prev_r.precharge_expired);

      det_topoff = rise(event_in.topoff_expired,
                        st_r.prev_r.topoff_expired);
   end

   // ------------------------------------------------------------------
   // Flag 2 assembly
   // ------------------------------------------------------------------
   // Bit 7 is reserved and stays clear
   always_comb
   begin
      set2 = 8'h00;
      set2[6] = det_data_line;
      set2[5] = det_conversion;
      set2[4] = det_min_system;
      set2[3] = det_fast_charge;
      set2[2] = det_trickle;
      set2[1] = det_precharge;
      set2[0] = det_topoff;
   end

   // ------------------------------------------------------------------
   // Fault capture: live protection levels, reserved bits held at zero
   // ------------------------------------------------------------------
   always_comb
   begin
      fault_now = CFS_REG_RESET;
      fault_now[CFS_FS_SYS_SHORT_BIT] = fault_in.system_short_status;
      fault_now[CFS_FS_SYS_OVP_BIT] = fault_in.system_overvoltage_status;
      fault_now[CFS_FS_REV_OVP_BIT] = fault_in.reverse_output_overvoltage_status;
      fault_now[CFS_FS_REV_UVP_BIT] = fault_in.reverse_output_undervoltage_status;
      fault_now[CFS_FS_TSHUT_BIT] = fault_in.thermal_shutdown_status;
   end

   // ------------------------------------------------------------------
   // Read decode: one register per request, unmapped offsets read zero
   // ------------------------------------------------------------------
   always_comb
   begin
      sel_fault = hit(rd_en, addr, CFS_FAULT_STATUS_1_OFF);
      sel_flag0 = hit(rd_en, addr, CFS_EVENT_FLAGS_0_OFF);
      sel_flag1 = hit(rd_en, addr, CFS_EVENT_FLAGS_1_OFF);
      sel_flag2 = hit(rd_en, addr, CFS_EVENT_FLAGS_2_OFF);
      rd_word = 8'h00;
      if (sel_fault)
      begin
         rd_word = st_r.fault_status_1_r & CFS_FS_USED_MASK;
      end
      else if (sel_flag0)
      begin
         rd_word = st_r.charger_event_flags_0_r;
      end
      else if (sel_flag1)
      begin
         rd_word = st_r.charger_event_flags_1_r & CFS_F1_USED_MASK;
      end
      else if (sel_flag2)
      begin
         rd_word = st_r.charger_event_flags_2_r & CFS_F2_USED_MASK;
      end
      else
      begin
         rd_word = 8'h00;
      end
   end

   // ------------------------------------------------------------------
   // Interrupt candidates: only flag 0 events have their mask here
   // ------------------------------------------------------------------
   // Other registers' masks live elsewhere, so their events never pulse here
   always_comb
   begin
      irq_candidates = set0 & ~event_mask;
   end

   // ------------------------------------------------------------------
   // Flag latching: events set, a read of the register clears
   // ------------------------------------------------------------------
   always_comb
   begin
      flags0_nxt = latch(st_r.charger_event_flags_0_r,
                         set0,
                         sel_flag0,
                         8'hFF);

      flags1_nxt = latch(st_r.charger_event_flags_1_r,
                         set1,
                         sel_flag1,
                         CFS_F1_USED_MASK);

      flags2_nxt = latch(st_r.charger_event_flags_2_r,
                         set2,
                         sel_flag2,
                         CFS_F2_USED_MASK);
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.prev_r = event_in;
      st_nxt.fault_status_1_r = fault_now;
      // Writes never touch the bank; wr_en and wr_data are accepted and dropped
      st_nxt.charger_event_flags_0_r = flags0_nxt;
      st_nxt.charger_event_flags_1_r = flags1_nxt;
      st_nxt.charger_event_flags_2_r = flags2_nxt;

      st_nxt.rd_valid_r = rd_en;
      st_nxt.rd_data_r = rd_word;

      st_nxt.event_pending_r = irq_candidates;
      // One cycle of staging keeps the pulse a clean flop output
      st_nxt.irq_pulse_r = |st_r.event_pending_r;

      // Reset overrides everything, including an event on the same edge
      if (!reset_n)
      begin
         st_nxt = '0;
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      st_r <= st_nxt;
   end

   assign rd_data = st_r.rd_data_r;
   assign rd_valid = st_r.rd_valid_r;
   assign irq_pulse = st_r.irq_pulse_r;

endmodule : cfs_flag_bank

`default_nettype wire

// ==== verification/cfs_flag_bank_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module cfs_flag_bank_monitor
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire cfs_pkg::cfs_fault_in_t fault_in,
   input wire cfs_pkg::cfs_event_in_t event_in,
   input wire logic [7:0] event_mask,
   input wire logic rd_en,
   input wire logic wr_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   input wire logic irq_pulse
);
   import cfs_pkg::*;
   // ----
   // Edge helper, cleared like the bank so events after reset match
   // ----
   logic [27:0] prv_r;
   logic [7:0] ev0;
   assign ev0 = {event_in[27:24] & ~prv_r[27:24], event_in[23:20] ^ prv_r[23:20]};
   always_ff @(posedge clk_sys) prv_r <= reset_n ? event_in : 28'h0000000;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   property p_valid; rd_en |=> rd_valid; endproperty
   a_valid: assert property (p_valid) else $error("read not answered");
   property p_wr; wr_en && !rd_en |=> !rd_valid; endproperty
   a_wr: assert property (p_wr) else $error("write answered");
   property p_fault; rd_en && addr == 8'h21 && $past(reset_n) |=>
      rd_data == {$past(fault_in[4:1], 2), 1'b0, $past(fault_in[0], 2), 2'b00}; endproperty
   a_fault: assert property (p_fault) else $error("fault read wrong");
   property p_unm; rd_en && (addr < 8'h21 || addr > 8'h24) |=> rd_data == 8'h00; endproperty
   a_unm: assert property (p_unm) else $error("unmapped read nonzero");
   property p_res1; rd_en && addr == 8'h23 |=> (rd_data & 8'h28) == 8'h00; endproperty
   a_res1: assert property (p_res1) else $error("reserved bit set");
   property p_res2; rd_en && addr == 8'h24 |=> !rd_data[7]; endproperty
   a_res2: assert property (p_res2) else $error("reserved bit set");
   property p_irq; |(ev0 & ~event_mask) |-> ##2 irq_pulse; endproperty
   a_irq: assert property (p_irq) else $error("pulse missing");
   property p_irqc; irq_pulse |-> $past(|(ev0 & ~event_mask), 2); endproperty
   a_irqc: assert property (p_irqc) else $error("pulse without event");
   property p_set; (|ev0) ##1 (rd_en && addr == 8'h22) |=>
      (rd_data & $past(ev0, 2)) == $past(ev0, 2); endproperty
   a_set: assert property (p_set) else $error("flag not latched");
endmodule : cfs_flag_bank_monitor
bind cfs_flag_bank cfs_flag_bank_monitor u_mon (.clk_sys(clk_sys), .reset_n(reset_n),
   .fault_in(fault_in), .event_in(event_in), .event_mask(event_mask), .rd_en(rd_en),
   .wr_en(wr_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
   .irq_pulse(irq_pulse));
`default_nettype wire

// ==== verification/cfs_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module cfs_host_model
(
   input wire logic clk_sys,
   output logic rd_en,
   output logic wr_en,
   output logic [7:0] addr,
   output logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid
);
   // ----
   // Host side; released lines show the inverse so stale values never pass
   // ----
   initial {rd_en, wr_en, addr, wr_data} = 18'h00000;
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(negedge clk_sys);
      {rd_en, addr} = {1'b1, a};
      @(negedge clk_sys);
      {rd_en, addr, ok, d} = {1'b0, ~a, rd_valid, rd_data};
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk_sys);
      {wr_en, addr, wr_data} = {1'b1, a, v};
      @(negedge clk_sys);
      {wr_en, addr, wr_data} = {1'b0, ~a, ~v};
   endtask : wr
endmodule : cfs_host_model
`default_nettype wire

// ==== verification/test_charger_fault_status_flag_bank.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_charger_fault_status_flag_bank;
   import cfs_pkg::*;
   logic clk_sys, reset_n, rd_en, wr_en, rd_valid, irq_pulse, ok, irq_e, pend;
   logic [7:0] event_mask, addr, wr_data, rd_data, d, fex;
   cfs_fault_in_t fault_in;
   cfs_event_in_t event_in;
   logic [27:0] prv;
   logic [23:0] exf, ev;
   logic [7:0] q[$];
   int n_mismatch = 0, num_checks = 0, k, j;
   cfs_flag_bank u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .fault_in(fault_in),
      .event_in(event_in), .event_mask(event_mask), .rd_en(rd_en), .wr_en(wr_en), .addr(addr),
      .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .irq_pulse(irq_pulse));
   cfs_host_model u_host (.clk_sys(clk_sys), .rd_en(rd_en), .wr_en(wr_en), .addr(addr),
      .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // ----
   // Reference model; a read returns old flags, events at that edge survive
   // ----
   function automatic logic [23:0] evf(logic [27:0] p, logic [27:0] c);
      logic [27:0] r;
      r = c & ~p;
      p = c ^ p;
      return {r[27:24], p[23:20], |p[19:17], |p[16:15], 1'b0, |p[14:11], 1'b0, r[10], p[9:8],
         1'b0, r[7], r[5] & c[6], p[4], r[3:0]};
   endfunction : evf
   always @(posedge clk_sys)
   begin
      ev = evf(prv, event_in);
      prv = reset_n ? event_in : 28'h0000000;
      if (rd_en && reset_n && addr == 8'h21) q.push_back(fex);
      else if (rd_en && reset_n && addr > 8'h21 && addr < 8'h25)
      begin
         j = int'(addr) - 8'h22;
         q.push_back(exf[23 - 8 * j -: 8]);
         exf[23 - 8 * j -: 8] = 8'h00;
      end
      else if (rd_en && reset_n) q.push_back(8'h00);
      exf = reset_n ? exf | ev : 24'h000000;
      fex = reset_n ? {fault_in[4:1], 1'b0, fault_in[0], 2'b00} : 8'h00;
      irq_e = reset_n & pend;
      pend = reset_n & (|(ev[23:16] & ~event_mask));
   end
   always @(negedge clk_sys) chk("irq_pulse", {7'h00, irq_e}, {7'h00, irq_pulse});
   // ----
   // Checks and verdict
   // ----
   task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] sn);
      num_checks++;
      if (sn !== ex)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, sn);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] a);
      u_host.rd(a, d, ok);
      chk("rd_valid", 8'h01, {7'h00, ok});
      chk("rd_data", q.pop_front(), d);
   endtask : rdc
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   initial
   begin
      repeat (100000) @(posedge clk_sys);
      n_mismatch++;
      final_report();
   end
   initial
   begin
      {reset_n, fault_in, event_in, event_mask} = 42'h0;
      repeat (16) @(negedge clk_sys);
      reset_n = 1'b1;
      void'($urandom(32'hfab3));
      for (k = 8'h21; k < 8'h25; k++) rdc(k[7:0]);
      for (k = 0; k < 32; k++)
      begin
         @(negedge clk_sys);
         fault_in = k[4:0];
         rdc(8'h21);
      end
      for (k = 0; k < 300; k++)
      begin
         event_mask = 8'($urandom);
         if (k == 150) reset_n = 1'b0;
         u_host.wr(8'h21 + 8'($urandom % 4), 8'($urandom));
         reset_n = 1'b1;
         fork
            rdc(8'h20 + 8'($urandom % 6));
            begin
               @(negedge clk_sys);
               event_in = cfs_event_in_t'(28'($urandom));
            end
         join
      end
      final_report();
   end
endmodule : test_charger_fault_status_flag_bank
`default_nettype wire
